//--- rtl/tcer_top.sv
// Purpose: Control and event routing for a two-half general purpose timer.
// Assumes: APB slave on sys_clk; events are one-cycle pulses from the
//          counting core, synchronous to sys_clk.
// Notes:   Counting itself lives in the core; this block gates and routes.
// How it works
// - Invert setting makes PWM output active low
// - Stall setting freezes counter during debug halt
// - ADC trigger only while its enable set
// - Chain wait holds half until upstream expiry
// - Any enabled DMA event starts a request; events in one cycle share it
// - DMA event enables read back as written in implemented bits, others zero
// - Nine interrupt sources each with enable, clear
// - Interrupt asserts only for pending enabled sources
// - Clear mask clears selected sources only
// - Status readable raw or masked
`timescale 1ns/1ps
`default_nettype none
`include "tcer_defines.svh"
module tcer_top
	import tcer_pkg::*;
#(
	parameter int PRESCALE_W = `TCER_PRESCALE_W
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic debug_halt,
	input wire logic chain_expiry_in,
	input wire logic [1:0] pwm_raw,
	input wire logic [1:0] expiry_evt,
	input wire logic [1:0] capture_edge_evt,
	input wire logic [1:0] capture_count_evt,
	input wire logic [1:0] mode_match_evt,
	input wire logic calendar_match_evt,
	input wire logic [1:0] dma_done_evt,
	input wire logic [PRESCALE_W-1:0] prescale_a,
	input wire logic [PRESCALE_W-1:0] prescale_b,
	output logic [1:0] pwm_out,
	output logic [1:0] adc_trigger,
	output logic [1:0] count_run,
	output logic dma_req,
	output logic timer_irq
);

	////////////////////////////////////////////////////////////////////////
	// Registers and decode

	tcer_word_t ctrl_r;
	tcer_word_t dmaev_r;
	tcer_word_t imask_r;
	tcer_word_t ris_r;
	tcer_word_t ris_nxt;
	tcer_word_t evt_vec;
	tcer_word_t dma_vec;
	tcer_word_t rd_nxt;
	tcer_word_t wmask;
	tcer_state_t state_a;
	tcer_state_t state_b;
	logic [1:0] run_w;
	logic access;
	logic wr_en;
	logic known;

	// Decode used by both read and write paths
	function automatic logic is_mapped(input logic [11:0] a);
		case (a)
			`TCER_CTRL_OFS, `TCER_DMAEV_OFS, `TCER_IMASK_OFS,
			`TCER_RIS_OFS, `TCER_MIS_OFS, `TCER_ICLR_OFS,
			`TCER_STAT_OFS:
				is_mapped = 1'b1;
			default:
				is_mapped = 1'b0;
		endcase
	endfunction

	// Byte strobes widened to a bit mask
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			wmask[i*8 +: 8] = {8{pstrb[i]}};
	end

	// Slave answers in the second access cycle, so one wait state
	assign access = psel && penable && !pready;
	assign known = is_mapped(paddr);
	assign wr_en = access && pwrite && known && clk_en;

	////////////////////////////////////////////////////////////////////////
	// APB handshake

	// One-cycle ready keeps every transfer at exactly three cycles
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (clk_en)
		begin
			pready <= psel && penable && !pready;
			pslverr <= access && !known;
		end
	end

	// Control register: enable, stall, invert, ADC and chain wait per half
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_r <= `TCER_CTRL_RST;
		else if (wr_en && paddr == `TCER_CTRL_OFS)
			ctrl_r <= (ctrl_r & ~wmask) |
				(pwdata & wmask & `TCER_CTRL_WMASK);
	end

	// DMA event enables, stored as written in the implemented bits only
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			dmaev_r <= `TCER_DMAEV_RST;
		else if (wr_en && paddr == `TCER_DMAEV_OFS)
			dmaev_r <= (dmaev_r & ~wmask) |
				(pwdata & wmask & `TCER_DMA_WMASK);
	end

	// Interrupt enable mask
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			imask_r <= `TCER_IMASK_RST;
		else if (wr_en && paddr == `TCER_IMASK_OFS)
			imask_r <= (imask_r & ~wmask) |
				(pwdata & wmask & `TCER_INT_WMASK);
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt sources

	// Pack event pulses into the status layout
	always_comb
	begin
		evt_vec = '0;
		evt_vec[`TCER_INT_TIMEOUT_A] = expiry_evt[0];
		evt_vec[`TCER_INT_CAPMATCH_A] = capture_count_evt[0];
		evt_vec[`TCER_INT_CAPEVENT_A] = capture_edge_evt[0];
		evt_vec[`TCER_INT_RTC] = calendar_match_evt;
		evt_vec[`TCER_INT_DMA_A] = dma_done_evt[0];
		evt_vec[`TCER_INT_TIMEOUT_B] = expiry_evt[1];
		evt_vec[`TCER_INT_CAPMATCH_B] = capture_count_evt[1];
		evt_vec[`TCER_INT_CAPEVENT_B] = capture_edge_evt[1];
		evt_vec[`TCER_INT_DMA_B] = dma_done_evt[1];
	end

	// Write-one-to-clear; a new event in the same cycle wins over the clear
	always_comb
	begin
		ris_nxt = ris_r;
		if (wr_en && paddr == `TCER_ICLR_OFS)
			ris_nxt = ris_nxt & ~(pwdata & wmask);
		ris_nxt = ris_nxt | evt_vec;
	end

	// Raw status ignores the enables
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			ris_r <= '0;
		else if (clk_en)
			ris_r <= ris_nxt & `TCER_INT_WMASK;
	end

	// Level interrupt from pending and enabled sources
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			timer_irq <= 1'b0;
		else if (clk_en)
			timer_irq <= |(ris_nxt & imask_r);
	end

	////////////////////////////////////////////////////////////////////////
	// DMA routing

	// Pack event pulses into the DMA enable layout
	always_comb
	begin
		dma_vec = '0;
		dma_vec[`TCER_DMA_TIMEOUT_A] = expiry_evt[0];
		dma_vec[`TCER_DMA_CAPMATCH_A] = capture_count_evt[0];
		dma_vec[`TCER_DMA_CAPEVENT_A] = capture_edge_evt[0];
		dma_vec[`TCER_DMA_RTC_A] = calendar_match_evt;
		dma_vec[`TCER_DMA_MODEMATCH_A] = mode_match_evt[0];
		dma_vec[`TCER_DMA_TIMEOUT_B] = expiry_evt[1];
		dma_vec[`TCER_DMA_CAPMATCH_B] = capture_count_evt[1];
		dma_vec[`TCER_DMA_CAPEVENT_B] = capture_edge_evt[1];
		dma_vec[`TCER_DMA_MODEMATCH_B] = mode_match_evt[1];
	end

	// Request pulse for any enabled event; events in one cycle share one pulse
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			dma_req <= 1'b0;
		else if (clk_en)
			dma_req <= |(dma_vec & dmaev_r);
	end

	////////////////////////////////////////////////////////////////////////
	// Per-half sequencing and outputs

	// Half B chains from half A; half A from the previous module
	tcer_half u_half_a (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.enable(ctrl_r[`TCER_CTRL_EN_A]),
		.chain_start_wait(ctrl_r[`TCER_CTRL_WAIT_A]),
		.chain_expiry_in(chain_expiry_in),
		.debug_freeze_select(ctrl_r[`TCER_CTRL_STALL_A]),
		.debug_halt(debug_halt),
		.count_run(run_w[0]),
		.state(state_a)
	);

	tcer_half u_half_b (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.enable(ctrl_r[`TCER_CTRL_EN_B]),
		.chain_start_wait(ctrl_r[`TCER_CTRL_WAIT_B]),
		.chain_expiry_in(expiry_evt[0]),
		.debug_freeze_select(ctrl_r[`TCER_CTRL_STALL_B]),
		.debug_halt(debug_halt),
		.count_run(run_w[1]),
		.state(state_b)
	);

	assign count_run = run_w;

	// PWM polarity and ADC trigger gating, registered
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pwm_out <= 2'h0;
			adc_trigger <= 2'h0;
		end
		else if (clk_en)
		begin
			pwm_out[0] <= pwm_raw[0] ^ ctrl_r[`TCER_CTRL_INV_A];
			pwm_out[1] <= pwm_raw[1] ^ ctrl_r[`TCER_CTRL_INV_B];
			adc_trigger[0] <= expiry_evt[0] &&
				ctrl_r[`TCER_CTRL_ADC_A];
			adc_trigger[1] <= expiry_evt[1] &&
				ctrl_r[`TCER_CTRL_ADC_B];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path

	// Read mux; unmapped addresses read zero with an error
	always_comb
	begin
		rd_nxt = '0;
		case (paddr)
			`TCER_CTRL_OFS: rd_nxt = ctrl_r;
			`TCER_DMAEV_OFS: rd_nxt = dmaev_r;
			`TCER_IMASK_OFS: rd_nxt = imask_r;
			`TCER_RIS_OFS: rd_nxt = ris_r;
			`TCER_MIS_OFS: rd_nxt = ris_r & imask_r;
			`TCER_STAT_OFS:
			begin
				rd_nxt[1:0] = state_a;
				rd_nxt[9:8] = state_b;
				rd_nxt[16 +: PRESCALE_W] = prescale_a;
				rd_nxt[24 +: PRESCALE_W] = prescale_b;
			end
			default: rd_nxt = '0;
		endcase
	end

	// Read data captured with ready
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			prdata <= '0;
		else if (clk_en && access && !pwrite)
			prdata <= rd_nxt;
	end

endmodule
`default_nettype wire

//--- rtl/tcer_defines.svh
// Purpose: Register offsets, field positions and reset values of the timer
//          control and event routing block.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes:   Definitions only.
`ifndef TCER_DEFINES_SVH
`define TCER_DEFINES_SVH

// Register byte offsets
`define TCER_CTRL_OFS 12'h000
`define TCER_DMAEV_OFS 12'h004
`define TCER_IMASK_OFS 12'h008
`define TCER_RIS_OFS 12'h00c
`define TCER_MIS_OFS 12'h010
`define TCER_ICLR_OFS 12'h014
`define TCER_STAT_OFS 12'h018

// Control register fields, half A in the low byte, half B in bits 15:8
`define TCER_CTRL_EN_A 0
`define TCER_CTRL_STALL_A 1
`define TCER_CTRL_INV_A 2
`define TCER_CTRL_ADC_A 3
`define TCER_CTRL_WAIT_A 4
`define TCER_CTRL_EN_B 8
`define TCER_CTRL_STALL_B 9
`define TCER_CTRL_INV_B 10
`define TCER_CTRL_ADC_B 11
`define TCER_CTRL_WAIT_B 12
`define TCER_CTRL_WMASK 32'h00001f1f

// DMA event enable fields
`define TCER_DMA_TIMEOUT_A 0
`define TCER_DMA_CAPMATCH_A 1
`define TCER_DMA_CAPEVENT_A 2
`define TCER_DMA_RTC_A 4
`define TCER_DMA_MODEMATCH_A 5
`define TCER_DMA_TIMEOUT_B 8
`define TCER_DMA_CAPMATCH_B 9
`define TCER_DMA_CAPEVENT_B 10
`define TCER_DMA_MODEMATCH_B 11
`define TCER_DMA_WMASK 32'h00000f37

// Interrupt source fields
`define TCER_INT_TIMEOUT_A 0
`define TCER_INT_CAPMATCH_A 1
`define TCER_INT_CAPEVENT_A 2
`define TCER_INT_RTC 3
`define TCER_INT_DMA_A 4
`define TCER_INT_TIMEOUT_B 8
`define TCER_INT_CAPMATCH_B 9
`define TCER_INT_CAPEVENT_B 10
`define TCER_INT_DMA_B 11
`define TCER_INT_WMASK 32'h00000f1f

// Reset values
`define TCER_CTRL_RST 32'h00000000
`define TCER_DMAEV_RST 32'h00000000
`define TCER_IMASK_RST 32'h00000000

// Prescaler width
`define TCER_PRESCALE_W 8

`endif

//--- rtl/tcer_pkg.sv
// Purpose: Types shared by the timer control and event routing block.
// Assumes: Offsets and fields live in tcer_defines.svh.
// Notes:   Types only.
package tcer_pkg;
	typedef logic [31:0] tcer_word_t;
	typedef enum logic [1:0] {TCER_OFF, TCER_WAIT, TCER_RUN} tcer_state_t;
endpackage

//--- rtl/tcer_half.sv
// Purpose: Per-half start sequencer: enable, chain wait and debug freeze.
// Assumes: Chain and debug inputs synchronous to sys_clk.
// Notes:   Instantiated once per timer half.
`timescale 1ns/1ps
`default_nettype none
module tcer_half
	import tcer_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic enable,
	input wire logic chain_start_wait,
	input wire logic chain_expiry_in,
	input wire logic debug_freeze_select,
	input wire logic debug_halt,
	output logic count_run,
	output tcer_state_t state
);

	tcer_state_t state_nxt;

	// Next state: waiting halves start on the upstream expiry
	always_comb
	begin
		state_nxt = state;
		case (state)
			TCER_OFF:
				if (enable)
					state_nxt = chain_start_wait ? TCER_WAIT : TCER_RUN;
			TCER_WAIT:
				if (!enable)
					state_nxt = TCER_OFF;
				else if (chain_expiry_in)
					state_nxt = TCER_RUN;
			TCER_RUN:
				if (!enable)
					state_nxt = TCER_OFF;
			default:
				state_nxt = TCER_OFF;
		endcase
	end

	// State register
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= TCER_OFF;
		else if (clk_en)
			state <= state_nxt;
	end

	// Count only while running and not frozen by debug
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			count_run <= 1'b0;
		else if (clk_en)
			count_run <= (state_nxt == TCER_RUN) &&
				!(debug_freeze_select && debug_halt);
	end

endmodule
`default_nettype wire

//--- testbench/tcer_monitor.sv
// Purpose: Port-level assertions for the timer control block.
// Assumes: clk_en high; a shadow of CTRL follows the APB writes.
// Notes:   Bound into tcer_top at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
`include "tcer_defines.svh"
module tcer_monitor
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic debug_halt,
	input wire logic [1:0] pwm_raw,
	input wire logic [1:0] expiry_evt,
	input wire logic [1:0] capture_edge_evt,
	input wire logic [1:0] capture_count_evt,
	input wire logic [1:0] mode_match_evt,
	input wire logic calendar_match_evt,
	input wire logic [1:0] dma_done_evt,
	input wire logic [1:0] pwm_out,
	input wire logic [1:0] adc_trigger,
	input wire logic [1:0] count_run,
	input wire logic dma_req,
	input wire logic timer_irq
);
	logic [31:0] ctrl_r;
	// Shadow CTRL on the edge where the write lands, not at pready
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_r <= 32'h0;
		else if (clk_en && psel && penable && !pready && pwrite
			&& paddr == `TCER_CTRL_OFS)
			ctrl_r <= pwdata & `TCER_CTRL_WMASK;
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_access;
		psel && !penable ##1 psel && penable;
	endsequence
	sequence s_answer;
		!pready ##1 pready;
	endsequence
	// Two cycles frozen covers either freeze latency
	sequence s_frozen_a;
		(!ctrl_r[0] || debug_halt && ctrl_r[1]) [*2];
	endsequence
	a_one_wait: assert property (s_access |-> s_answer)
		else $error("pready not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_map: assert property (pready |-> pslverr == (paddr > 12'h018))
		else $error("pslverr wrong for address");
	a_clr_reads0: assert property (pready && !pwrite && paddr == 12'h014
		|-> prdata == 32'h0) else $error("clear register read nonzero");
	a_pwm_pol: assert property (clk_en |=> pwm_out ==
		$past(pwm_raw ^ {ctrl_r[10], ctrl_r[2]})) else $error("pwm polarity");
	a_adc_gate: assert property (clk_en |=> adc_trigger ==
		$past(expiry_evt & {ctrl_r[11], ctrl_r[3]})) else $error("adc trigger");
	a_run_gate: assert property (s_frozen_a |-> !count_run[0])
		else $error("half A runs while off or frozen");
	a_dma_cause: assert property (dma_req |-> $past(|{mode_match_evt,
		expiry_evt, capture_edge_evt, capture_count_evt, calendar_match_evt}))
		else $error("dma request without event");
	a_irq_cause: assert property ($rose(timer_irq) |->
		$past(|{capture_edge_evt, capture_count_evt, calendar_match_evt,
		expiry_evt, dma_done_evt}) || $past(psel && pwrite))
		else $error("interrupt without cause");
endmodule
bind tcer_top tcer_monitor mon (.*);
`default_nettype wire

//--- testbench/tcer_core_model.sv
// Purpose: Counting core seen from the control block.
// Assumes: Runs a half only while count_run is high.
// Notes:   Short period keeps expiry frequent.
`timescale 1ns/1ps
`default_nettype none
module tcer_core_model
#(
	parameter int PERIOD = 8
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [1:0] count_run,
	output logic [1:0] pwm_raw,
	output logic [1:0] expiry_evt,
	output logic [7:0] prescale_a,
	output logic [7:0] prescale_b
);
	logic [1:0][3:0] cnt_r;
	// Prescale values stay in the eight-bit range
	assign prescale_a = 8'hff;
	assign prescale_b = 8'h00;
	////////////////////////////////////////////////////////////////////////
	// A stopped half holds its pwm level and gives no expiry
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_r <= '0;
			pwm_raw <= 2'h0;
			expiry_evt <= 2'h0;
		end
		else
			for (int i = 0; i < 2; i++)
			begin
				expiry_evt[i] <= count_run[i] && cnt_r[i] == 4'(PERIOD - 1);
				if (count_run[i])
				begin
					cnt_r[i] <= (cnt_r[i] == 4'(PERIOD - 1)) ? 4'h0 : cnt_r[i] + 4'h1;
					pwm_raw[i] <= cnt_r[i] < 4'(PERIOD / 2);
				end
			end
	end
endmodule
`default_nettype wire

//--- testbench/tb_tcer_top.sv
// Purpose: Self-checking bench for the timer control block.
// Assumes: APB master tasks; core model drives pwm and expiry.
// Notes:   Chain start of half A is tied off.
`timescale 1ns/1ps
`default_nettype none
`include "tcer_defines.svh"
module tb_tcer_top;
	import tcer_pkg::*;
	logic sys_clk, rst_n, psel, penable, pwrite, debug_halt;
	logic pready, pslverr, dma_req, timer_irq;
	logic [11:0] paddr;
	tcer_word_t pwdata, prdata, q;
	logic [8:0] evv;
	logic [1:0] pwm_raw, expiry_evt, pwm_out, adc_trigger, count_run;
	logic [7:0] pre_a, pre_b;
	int bad_count = 0, n_tests = 0, n_dma = 0, n_adc = 0, k, i;
	tcer_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .debug_halt(debug_halt), .chain_expiry_in(1'b0),
		.pwm_raw(pwm_raw), .expiry_evt(expiry_evt),
		.capture_edge_evt(evv[1:0]), .capture_count_evt(evv[3:2]),
		.mode_match_evt(evv[5:4]), .dma_done_evt(evv[7:6]),
		.calendar_match_evt(evv[8]), .prescale_a(pre_a), .prescale_b(pre_b),
		.pwm_out(pwm_out), .adc_trigger(adc_trigger), .count_run(count_run),
		.dma_req(dma_req), .timer_irq(timer_irq));
	tcer_core_model core (.sys_clk(sys_clk), .rst_n(rst_n),
		.count_run(count_run), .pwm_raw(pwm_raw), .expiry_evt(expiry_evt),
		.prescale_a(pre_a), .prescale_b(pre_b));
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Pulse counters, so short outputs are never missed
	always @(posedge sys_clk)
	begin
		if (dma_req === 1'b1) n_dma++;
		if (adc_trigger[0] === 1'b1) n_adc++;
	end
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input tcer_word_t got, input tcer_word_t exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	// Hold the request until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input tcer_word_t d);
		int n;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		q = prdata;
		psel <= 0;
		penable <= 0;
		if (n >= 20)
		begin
			bad_count++;
			print_verdict;
		end
		// One idle edge, so a following call never reassigns psel at once
		@(posedge sys_clk);
	endtask
	task automatic rc(input logic [11:0] a, input tcer_word_t e);
		apb(0, a, 0);
		chk(q, e);
	endtask
	task automatic ev(input logic [8:0] v);
		evv <= v;
		@(posedge sys_clk);
		evv <= 0;
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic hold(input logic [15:0] d, input int b, input logic e);
		apb(1, 12'h000, {16'h0, d});
		repeat (20) @(posedge sys_clk);
		chk({31'h0, count_run[b]}, {31'h0, e});
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{psel, penable, pwrite, debug_halt, paddr, pwdata, evv, rst_n} = '0;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1;
		@(posedge sys_clk);
		rc(12'h000, 32'h0);
		rc(12'h008, 32'h0);
		rc(12'h100, 32'h0);
		apb(1, 12'h004, 32'hffffffff);
		rc(12'h004, `TCER_DMA_WMASK);
		// Only mode match of half A may request
		apb(1, 12'h004, 32'h20);
		k = n_dma;
		ev(9'h1ef);
		chk(32'(n_dma - k), 32'h0);
		ev(9'h010);
		chk(32'(n_dma - k), 32'h1);
		// Raw flags set while masked, then mask and clear
		apb(1, 12'h014, 32'hffffffff);
		ev(9'h1ff);
		rc(12'h00c, 32'h00000e1e);
		chk({31'h0, timer_irq}, 32'h0);
		rc(12'h010, 32'h0);
		apb(1, 12'h008, 32'h4);
		rc(12'h010, 32'h4);
		chk({31'h0, timer_irq}, 32'h1);
		apb(1, 12'h014, 32'he1a);
		rc(12'h00c, 32'h4);
		apb(1, 12'h014, 32'h4);
		chk({31'h0, timer_irq}, 32'h0);
		// Half A runs with freeze armed, then debug halts it
		k = n_adc;
		hold(12'h00b, 0, 1);
		chk({31'h0, n_adc > k}, 32'h1);
		debug_halt <= 1;
		hold(12'h00b, 0, 0);
		hold(12'h009, 0, 1);
		debug_halt <= 0;
		k = n_adc;
		hold(12'h001, 0, 1);
		// Count only after the cleared enable has settled
		k = n_adc;
		repeat (20) @(posedge sys_clk);
		chk({31'h0, n_adc == k}, 32'h1);
		hold(12'h004, 0, 0);
		chk({31'h0, pwm_out[0]}, {31'h0, ~pwm_raw[0]});
		hold(12'h000, 0, 0);
		chk({31'h0, pwm_out[0]}, {31'h0, pwm_raw[0]});
		// Wait is only ever set on half B, started by half A
		hold(16'h1100, 1, 0);
		rc(12'h018, 32'h00ff0100);
		apb(1, 12'h000, 32'h1101);
		i = 0;
		while (count_run[1] !== 1'b1 && i < 40)
		begin
			@(posedge sys_clk);
			i++;
		end
		chk({31'h0, count_run[1]}, 32'h1);
		print_verdict;
	end
endmodule
`default_nettype wire
